// ---- ulev_pkg.sv ----
// Shared constants and the small change detector for the ULPI event block.
package ulev_pkg;
  // Register byte offsets.
  localparam logic [7:0] ULEV_CTRL_OFS   = 8'h00;
  localparam logic [7:0] ULEV_STATUS_OFS = 8'h04;
  // Control register fields.
  localparam int ULEV_FAULT_POL_BIT   = 0;
  localparam int ULEV_EXT_FAULT_BIT   = 1;
  localparam int ULEV_BYPASS_BIT      = 2;
  localparam int ULEV_PLUS_PD_BIT     = 3;
  localparam int ULEV_MINUS_PD_BIT    = 4;
  localparam int ULEV_DET_RISE_BIT    = 5;
  localparam int ULEV_DET_FALL_BIT    = 6;
  localparam int ULEV_VBUS_RISE_BIT   = 7;
  localparam int ULEV_VBUS_FALL_BIT   = 8;
  localparam int ULEV_CTRL_W          = 9;
  localparam logic [ULEV_CTRL_W-1:0] ULEV_CTRL_RST = 9'h000;
  // Status register fields.
  localparam int ULEV_ST_VBUS_LO   = 0;
  localparam int ULEV_ST_DETACH    = 2;
  localparam int ULEV_ST_EVENT_LO  = 3;
  localparam int ULEV_ST_DIR       = 5;
  localparam int ULEV_ST_ABORT_LO  = 8;
  localparam int ULEV_ABORT_W      = 8;
  // Receive command byte layout.
  localparam int ULEV_RXCMD_LS_LO    = 0;
  localparam int ULEV_RXCMD_VBUS_LO  = 2;
  localparam int ULEV_RXCMD_EVENT_LO = 4;
  localparam int ULEV_RXCMD_ID       = 6;
  localparam int ULEV_RXCMD_ALT      = 7;
  // Receive event codes.
  localparam logic [1:0] ULEV_EV_IDLE   = 2'h0;
  localparam logic [1:0] ULEV_EV_ACTIVE = 2'h1;
  localparam logic [1:0] ULEV_EV_ERROR  = 2'h3;
  localparam logic [1:0] ULEV_EV_DETACH = 2'h2;
  // Bus power level codes.
  localparam logic [1:0] ULEV_VB_LOW    = 2'h0;
  localparam logic [1:0] ULEV_VB_END    = 2'h1;
  localparam logic [1:0] ULEV_VB_SESS   = 2'h2;
  localparam logic [1:0] ULEV_VB_AVALID = 2'h3;

  typedef enum logic [2:0] {ST_IDLE, ST_TURN, ST_CMD, ST_RX, ST_GAP} ulev_state_type;
endpackage : ulev_pkg

`timescale 1ns/100ps
module ulev_edge #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Watched value and its change pulses.
  input  wire logic [W-1:0] d,
  output logic              changed,
  output logic              up,
  output logic              down
);
  logic [W-1:0] prev;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prev <= '0;
    else
      prev <= d;
  end

  assign changed = (d != prev);
  assign up      = (d > prev);
  assign down    = (d < prev);
endmodule : ulev_edge

// ---- ulev_event_phy.sv ----
// Device-side ULPI receive event signalling, bus power reporting and register bus.
`timescale 1ns/100ps
module ulev_event_phy
  import ulev_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Analog front end and pins.
  input  wire logic [1:0]  line_state,
  input  wire logic        session_end,
  input  wire logic        session_valid,
  input  wire logic        a_device_bus_power_valid,
  input  wire logic        fault_in,
  input  wire logic        id_in,
  input  wire logic        host_detach_in,
  // Receive path from the serial engine.
  input  wire logic        rx_sync,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_error,
  input  wire logic        rx_end,
  // Register access engine.
  input  wire logic        reg_busy,
  output logic             reg_abort,
  // ULPI link side.
  output logic             ulpi_dir,
  output logic             ulpi_nxt,
  output logic [7:0]       ulpi_data_out,
  output logic             ulpi_data_oe,
  // Configuration levels for the analog part.
  output logic             plus_line_pulldown,
  output logic             minus_line_pulldown
);
  import ulev_pkg::*;

  logic [ULEV_CTRL_W-1:0]  ctrl;
  logic [ULEV_ABORT_W-1:0] abort_count;
  ulev_state_type          state;
  logic                    fault_active;
  logic                    a_valid_eff;
  logic [1:0]              vbus_code;
  logic                    detach;
  logic [1:0]              rx_event;
  logic [7:0]              rxcmd;
  logic                    pending;
  logic                    pend_set;
  logic                    pend_clr;
  logic                    rx_mode;
  logic                    err_seen;
  logic                    ls_chg;
  logic                    vb_chg;
  logic                    vb_up;
  logic                    vb_down;
  logic                    det_up;
  logic                    det_down;
  logic                    dir_rise;

  assign plus_line_pulldown  = ctrl[ULEV_PLUS_PD_BIT];
  assign minus_line_pulldown = ctrl[ULEV_MINUS_PD_BIT];

  // A complemented fault input is normalised here so everything below is active high.
  assign fault_active = fault_in ^ ctrl[ULEV_FAULT_POL_BIT];
  always_comb
  begin
    if (!ctrl[ULEV_EXT_FAULT_BIT])
      a_valid_eff = a_device_bus_power_valid;
    else if (ctrl[ULEV_BYPASS_BIT])
      a_valid_eff = !fault_active;
    else
      a_valid_eff = a_device_bus_power_valid && !fault_active;
  end

  always_comb
  begin
    if (a_valid_eff)
      vbus_code = ULEV_VB_AVALID;
    else if (session_valid)
      vbus_code = ULEV_VB_SESS;
    else if (!session_end)
      vbus_code = ULEV_VB_END;
    else
      vbus_code = ULEV_VB_LOW;
  end

  // Detach is forced low outside host role so a floating comparator cannot report.
  assign detach = plus_line_pulldown && minus_line_pulldown && host_detach_in;

  ulev_edge #(.W(2)) u_ls_edge (
    .clk(clk), .rst_n(rst_n), .d(line_state), .changed(ls_chg), .up(), .down()
  );
  ulev_edge #(.W(2)) u_vb_edge (
    .clk(clk), .rst_n(rst_n), .d(vbus_code), .changed(vb_chg), .up(vb_up), .down(vb_down)
  );
  ulev_edge #(.W(1)) u_det_edge (
    .clk(clk), .rst_n(rst_n), .d(detach), .changed(), .up(det_up), .down(det_down)
  );

  always_comb
  begin
    if (detach)
      rx_event = ULEV_EV_DETACH;
    else if (rx_mode && (err_seen || rx_error))
      rx_event = ULEV_EV_ERROR;
    else if (rx_mode)
      rx_event = ULEV_EV_ACTIVE;
    else
      rx_event = ULEV_EV_IDLE;
  end

  always_comb
  begin
    rxcmd = 8'h00;
    rxcmd[ULEV_RXCMD_LS_LO +: 2]    = line_state;
    rxcmd[ULEV_RXCMD_VBUS_LO +: 2]  = vbus_code;
    rxcmd[ULEV_RXCMD_EVENT_LO +: 2] = rx_event;
    rxcmd[ULEV_RXCMD_ID]            = id_in;
    rxcmd[ULEV_RXCMD_ALT]           = 1'b0;
  end

  assign pend_set = ls_chg
                 || (vb_up && ctrl[ULEV_VBUS_RISE_BIT]) || (vb_down && ctrl[ULEV_VBUS_FALL_BIT])
                 || (det_up && ctrl[ULEV_DET_RISE_BIT])
                 || (det_down && ctrl[ULEV_DET_FALL_BIT]);
  assign pend_clr = (state == ST_CMD) || (state == ST_RX && !rx_valid);

  // A new change in the sending cycle keeps the flag; an earlier one is cleared in any ST_RX cycle with rx_valid low, which sends rxcmd unless dir drops.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pending <= 1'b0;
    else if (pend_set)
      pending <= 1'b1;
    else if (pend_clr)
      pending <= 1'b0;
  end

  assign dir_rise = (state == ST_IDLE) && (rx_sync || pending);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state <= ST_IDLE;
    else
      case (state)
        ST_IDLE: if (dir_rise) state <= ST_TURN;
        ST_TURN: state <= rx_mode ? ST_RX : ST_CMD;
        ST_CMD:  state <= ST_GAP;
        ST_RX:   if (rx_end || err_seen) state <= ST_GAP;
        ST_GAP:  state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rx_mode <= 1'b0;
    else if (state == ST_IDLE && rx_sync)
      rx_mode <= 1'b1;
    else if (state == ST_GAP)
      rx_mode <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      err_seen <= 1'b0;
    else if (state == ST_GAP)
      err_seen <= 1'b0;
    else if (rx_mode && rx_error)
      err_seen <= 1'b1;
  end

  // Link-facing outputs are registered, so the bus sees no decode glitches.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ulpi_dir      <= 1'b0;
      ulpi_nxt      <= 1'b0;
      ulpi_data_out <= 8'h00;
      ulpi_data_oe  <= 1'b0;
    end
    else
      case (state)
        ST_IDLE:
        begin
          ulpi_dir     <= dir_rise;
          ulpi_nxt     <= rx_sync;
          ulpi_data_oe <= 1'b0;
        end
        ST_TURN, ST_CMD:
        begin
          ulpi_dir      <= (state == ST_TURN);
          ulpi_nxt      <= 1'b0;
          ulpi_data_out <= rxcmd;
          ulpi_data_oe  <= (state == ST_TURN);
        end
        ST_RX:
        begin
          ulpi_dir      <= !(rx_end || err_seen);
          ulpi_nxt      <= rx_valid && !rx_error && !err_seen;
          ulpi_data_out <= (rx_valid && !rx_error && !err_seen) ? rx_byte : rxcmd;
          ulpi_data_oe  <= !(rx_end || err_seen);
        end
        default:
        begin
          ulpi_dir     <= 1'b0;
          ulpi_nxt     <= 1'b0;
          ulpi_data_oe <= 1'b0;
        end
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reg_abort   <= 1'b0;
      abort_count <= '0;
    end
    else
    begin
      reg_abort <= dir_rise && reg_busy;
      if (dir_rise && reg_busy)
        abort_count <= abort_count + 1'b1;
    end
  end

  // APB: zero wait states; data and error are latched in the setup cycle.
  assign pready = 1'b1;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ctrl <= ULEV_CTRL_RST;
    else if (psel && penable && pwrite && paddr == ULEV_CTRL_OFS)
      ctrl <= pwdata[ULEV_CTRL_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      if (paddr == ULEV_CTRL_OFS)
        prdata[ULEV_CTRL_W-1:0] <= ctrl;
      else if (paddr == ULEV_STATUS_OFS && !pwrite)
      begin
        prdata[ULEV_ST_VBUS_LO +: 2]             <= vbus_code;
        prdata[ULEV_ST_DETACH]                   <= detach;
        prdata[ULEV_ST_EVENT_LO +: 2]            <= rx_event;
        prdata[ULEV_ST_DIR]                      <= ulpi_dir;
        prdata[ULEV_ST_ABORT_LO +: ULEV_ABORT_W] <= abort_count;
      end
      else
        pslverr <= 1'b1;
    end
  end

  // Checks.
  sequence s_sync_idle;
    state == ST_IDLE && rx_sync;
  endsequence
  sequence s_active_pair;
    ulpi_dir && ulpi_nxt;
  endsequence

  a_sync_dir_nxt: assert property (@(posedge clk) disable iff (!rst_n)
    s_sync_idle |=> s_active_pair) else $error("sync did not raise dir with nxt");
  a_abort_dir: assert property (@(posedge clk) disable iff (!rst_n)
    (dir_rise && reg_busy) |=> reg_abort && ulpi_dir) else $error("register op not aborted");
  a_no_abort: assert property (@(posedge clk) disable iff (!rst_n)
    !(dir_rise && reg_busy) |=> !reg_abort) else $error("spurious abort");
  a_err_nxt_low: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_RX && rx_error) |=> !ulpi_nxt
      && ulpi_data_out[ULEV_RXCMD_EVENT_LO +: 2] == ULEV_EV_ERROR) else $error("error not shown");
  a_detach_host: assert property (@(posedge clk) disable iff (!rst_n)
    !(plus_line_pulldown && minus_line_pulldown) |-> !detach) else $error("detach outside host");
  a_vbus_top: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl[ULEV_EXT_FAULT_BIT] && ctrl[ULEV_BYPASS_BIT] && !fault_active)
      |-> vbus_code == ULEV_VB_AVALID) else $error("bypass fault not reported");
  a_fault_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl[ULEV_EXT_FAULT_BIT] && !ctrl[ULEV_BYPASS_BIT] && !a_device_bus_power_valid)
      |-> vbus_code != ULEV_VB_AVALID) else $error("fault not qualified");
  a_det_rise_cmd: assert property (@(posedge clk) disable iff (!rst_n)
    (det_up && ctrl[ULEV_DET_RISE_BIT] && state == ST_IDLE && !pending && !rx_sync)
      ##1 !rx_sync
      |=> ulpi_dir ##1 ulpi_dir && !ulpi_nxt
      && ulpi_data_out[ULEV_RXCMD_EVENT_LO +: 2] == ULEV_EV_DETACH) else $error("no detach cmd");
  a_rx_frame: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_RX && !rx_end && !err_seen) |=> ulpi_dir) else $error("dir dropped in packet");
endmodule : ulev_event_phy

// ---- ulev_link_model.sv ----
// Behavioural link controller facing the device side of the ULPI port.
`timescale 1ns/100ps
module ulev_link_model (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Device side of the link.
  input  wire logic       ulpi_dir,
  input  wire logic       ulpi_nxt,
  input  wire logic [7:0] ulpi_data_out,
  input  wire logic       ulpi_data_oe,
  input  wire logic       reg_abort,
  // Bench control and observed results.
  input  wire logic       reg_start,
  output logic            reg_busy,
  output logic [7:0]      last_cmd,
  output logic [7:0]      cmd_count,
  output logic [7:0]      good_pkts,
  output logic [7:0]      bad_pkts,
  output logic [7:0]      pkt_bytes,
  output logic [7:0]      reg_done,
  output logic [7:0]      retries
);
  import ulev_pkg::*;
  logic             dir_q, active, err_seen, pend;
  logic [1:0]       cnt;
  wire  logic [1:0] ev = ulpi_data_out[ULEV_RXCMD_EVENT_LO +: 2];
  wire  logic       is_cmd = ulpi_dir && ulpi_data_oe && !ulpi_nxt;
  // Whichever comes first ends the packet, so a late command byte is never needed.
  wire  logic       ending = active && ((dir_q && !ulpi_dir) || (is_cmd && ev == ULEV_EV_IDLE));
  always_ff @(posedge clk)
    if (!rst_n)
    begin
      {dir_q, active, err_seen} <= 3'h0;
      {last_cmd, cmd_count, good_pkts, bad_pkts, pkt_bytes} <= 40'h0;
    end
    else
    begin
      dir_q <= ulpi_dir;
      if (is_cmd)
      begin
        last_cmd <= ulpi_data_out;
        cmd_count <= cmd_count + 8'h01;
      end
      if (ulpi_dir && ulpi_nxt && !dir_q)
      begin
        active <= 1'h1;
        err_seen <= 1'h0;
        pkt_bytes <= 8'h00;
      end
      else if (ulpi_dir && ulpi_nxt && ulpi_data_oe)
        pkt_bytes <= pkt_bytes + 8'h01;
      if (is_cmd && (ev == ULEV_EV_ACTIVE || ev == ULEV_EV_ERROR))
        active <= 1'h1;
      if (is_cmd && ev == ULEV_EV_ERROR)
        err_seen <= 1'h1;
      if (ending)
      begin
        active <= 1'h0;
        if (err_seen)
          bad_pkts <= bad_pkts + 8'h01;
        else
          good_pkts <= good_pkts + 8'h01;
      end
    end
  // An aborted operation waits for direction to fall before it is tried again.
  always_ff @(posedge clk)
    if (!rst_n)
      {reg_busy, pend, cnt, reg_done, retries} <= 20'h0;
    else if (reg_busy && reg_abort)
    begin
      {reg_busy, pend} <= 2'h1;
      retries <= retries + 8'h01;
    end
    else if (!reg_busy && (reg_start || pend) && !ulpi_dir)
      {reg_busy, pend, cnt} <= 4'h8;
    else if (reg_busy)
    begin
      cnt <= cnt + 2'h1;
      if (cnt == 2'h3)
      begin
        reg_busy <= 1'h0;
        reg_done <= reg_done + 8'h01;
      end
    end
endmodule : ulev_link_model

// ---- test_ulev_event_phy.sv ----
// Self-checking bench for the ULPI event block against a behavioural link.
`timescale 1ns/100ps
module test_ulev_event_phy;
  import ulev_pkg::*;
  logic        clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00, rx_byte = 8'h00, ncmd = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [1:0]  line_state = 2'h0;
  logic        session_end = 1'h1, session_valid = 1'h0, a_valid = 1'h0, fault_in = 1'h0;
  logic        id_in = 1'h0, detach = 1'h0, reg_start = 1'h0;
  logic        rx_sync = 1'h0, rx_valid = 1'h0, rx_error = 1'h0, rx_end = 1'h0;
  logic        pready, pslverr, reg_busy, reg_abort, ulpi_dir, ulpi_nxt, ulpi_data_oe;
  logic        plus_pd, minus_pd;
  logic [7:0]  ulpi_data_out, last_cmd, cmd_count, good_pkts, bad_pkts, pkt_bytes;
  logic [7:0]  reg_done, retries;
  int          mismatches = 0, compares = 0, cycles = 0;

  always #50 clk = ~clk;

  ulev_event_phy u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .line_state(line_state), .session_end(session_end),
    .session_valid(session_valid), .a_device_bus_power_valid(a_valid), .fault_in(fault_in),
    .id_in(id_in), .host_detach_in(detach), .rx_sync(rx_sync), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_error(rx_error), .rx_end(rx_end), .reg_busy(reg_busy),
    .reg_abort(reg_abort), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt),
    .ulpi_data_out(ulpi_data_out), .ulpi_data_oe(ulpi_data_oe),
    .plus_line_pulldown(plus_pd), .minus_line_pulldown(minus_pd));
  ulev_link_model u_link (.clk(clk), .rst_n(rst_n), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt),
    .ulpi_data_out(ulpi_data_out), .ulpi_data_oe(ulpi_data_oe), .reg_abort(reg_abort),
    .reg_start(reg_start), .reg_busy(reg_busy), .last_cmd(last_cmd), .cmd_count(cmd_count),
    .good_pkts(good_pkts), .bad_pkts(bad_pkts), .pkt_bytes(pkt_bytes),
    .reg_done(reg_done), .retries(retries));

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do
      @(posedge clk);
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wreg(input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'h1, ULEV_CTRL_OFS, d, r, e);
  endtask : wreg

  task automatic exp_cmd(input logic [7:0] e);
    while (cmd_count === ncmd)
      @(posedge clk);
    ncmd = ncmd + 8'h01;
    chk("command byte", {24'h0, e}, {24'h0, last_cmd});
  endtask : exp_cmd

  task automatic no_cmd();
    repeat (12) @(posedge clk);
    chk("command count", {24'h0, ncmd}, {24'h0, cmd_count});
  endtask : no_cmd

  task automatic wait_done(input logic [7:0] n);
    while (reg_done !== n)
      @(posedge clk);
  endtask : wait_done

  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    apb(1'h0, ULEV_CTRL_OFS, 32'h0, r, e);
    chk("ctrl reset", {23'h0, ULEV_CTRL_RST}, r);
    wreg(32'h18);
    apb(1'h0, ULEV_CTRL_OFS, 32'h0, r, e);
    chk("ctrl readback", 32'h18, r);
    chk("pulldowns", 32'h3, {30'h0, plus_pd, minus_pd});
    apb(1'h0, 8'h08, 32'h0, r, e);
    chk("unmapped read", 32'h1, {r[30:0], e});
    apb(1'h1, ULEV_STATUS_OFS, 32'h5, r, e);
    chk("status write", 32'h1, {31'h0, e});
    wreg(32'h0);
  endtask : t_regs

  task automatic t_line();
    logic [1:0] ls;
    ls = 2'h2;
    @(posedge clk) line_state <= 2'h1;
    id_in <= 1'h1;
    exp_cmd({1'h0, 1'h1, ULEV_EV_IDLE, ULEV_VB_LOW, 2'h1});
    @(posedge clk) line_state <= 2'h2;
    id_in <= 1'h0;
    exp_cmd({2'h0, ULEV_EV_IDLE, ULEV_VB_LOW, 2'h2});
    // A chirp walk: three K-J pairs ending on line state 2, each level reported once.
    for (int i = 0; i < 6; i++)
    begin
      ls = ls ^ 2'h3;
      @(posedge clk) line_state <= ls;
      exp_cmd({2'h0, ULEV_EV_IDLE, ULEV_VB_LOW, ls});
    end
  endtask : t_line

  task automatic t_fault();
    logic [8:0]  cfg [4] = '{9'h006, 9'h002, 9'h007, 9'h002};
    logic [1:0]  xp [4] = '{2'h3, 2'h2, 2'h3, 2'h3};
    logic [3:0]  fl = 4'h4;
    logic [3:0]  av = 4'h8;
    logic [31:0] r;
    logic        e;
    @(posedge clk) session_end <= 1'h0;
    session_valid <= 1'h1;
    for (int i = 0; i < 4; i++)
    begin
      wreg({23'h0, cfg[i]});
      @(posedge clk) fault_in <= fl[i];
      a_valid <= av[i];
      repeat (3) @(posedge clk);
      apb(1'h0, ULEV_STATUS_OFS, 32'h0, r, e);
      chk("power code", {30'h0, xp[i]}, {30'h0, r[1:0]});
    end
    @(posedge clk) {fault_in, a_valid, session_end, session_valid} <= 4'h2;
    wreg(32'h0);
    no_cmd();
  endtask : t_fault

  task automatic t_vbus();
    wreg(32'h80);
    @(posedge clk) session_end <= 1'h0;
    exp_cmd({2'h0, ULEV_EV_IDLE, ULEV_VB_END, 2'h2});
    @(posedge clk) session_valid <= 1'h1;
    exp_cmd({2'h0, ULEV_EV_IDLE, ULEV_VB_SESS, 2'h2});
    @(posedge clk) {session_end, session_valid} <= 2'h2;
    no_cmd();
    wreg(32'h0);
  endtask : t_vbus

  task automatic t_detach();
    logic [31:0] r;
    logic        e;
    wreg(32'h38);
    @(posedge clk) detach <= 1'h1;
    exp_cmd({2'h0, ULEV_EV_DETACH, ULEV_VB_LOW, 2'h2});
    apb(1'h0, ULEV_STATUS_OFS, 32'h0, r, e);
    chk("detach status", 32'h1, {31'h0, r[ULEV_ST_DETACH]});
    @(posedge clk) detach <= 1'h0;
    no_cmd();
    wreg(32'h78);
    @(posedge clk) detach <= 1'h1;
    exp_cmd({2'h0, ULEV_EV_DETACH, ULEV_VB_LOW, 2'h2});
    @(posedge clk) detach <= 1'h0;
    exp_cmd({2'h0, ULEV_EV_IDLE, ULEV_VB_LOW, 2'h2});
    wreg(32'h0);
  endtask : t_detach

  task automatic rx_pkt(input int n, input logic err);
    @(posedge clk) reg_start <= 1'h0;
    rx_sync <= 1'h1;
    @(posedge clk) rx_sync <= 1'h0;
    #1;
    chk("dir with nxt", 32'h3, {30'h0, ulpi_dir, ulpi_nxt});
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk) rx_valid <= 1'h1;
      rx_byte <= 8'h30 + 8'(i);
    end
    @(posedge clk) {rx_valid, rx_error, rx_end} <= {1'h0, err, !err};
    @(posedge clk) {rx_error, rx_end} <= 2'h0;
    while (ulpi_dir !== 1'h0)
      @(posedge clk);
    repeat (2) @(posedge clk);
    ncmd = cmd_count;
  endtask : rx_pkt

  task automatic t_rx();
    rx_pkt(3, 1'h0);
    chk("good packets", 32'h1, {24'h0, good_pkts});
    chk("packet bytes", 32'h3, {24'h0, pkt_bytes});
    rx_pkt(2, 1'h1);
    chk("error event", {30'h0, ULEV_EV_ERROR}, {30'h0, last_cmd[5:4]});
    chk("bad packets", 32'h1, {24'h0, bad_pkts});
  endtask : t_rx

  task automatic t_abort();
    logic [31:0] r;
    logic        e;
    @(posedge clk) reg_start <= 1'h1;
    @(posedge clk) reg_start <= 1'h0;
    wait_done(8'h01);
    chk("clean retries", 32'h0, {24'h0, retries});
    @(posedge clk) reg_start <= 1'h1;
    rx_pkt(1, 1'h0);
    wait_done(8'h02);
    chk("abort retries", 32'h1, {24'h0, retries});
    chk("ops done", 32'h2, {24'h0, reg_done});
    apb(1'h0, ULEV_STATUS_OFS, 32'h0, r, e);
    chk("abort count", 32'h1, {24'h0, r[ULEV_ST_ABORT_LO +: 8]});
  endtask : t_abort

  // A hang anywhere still ends in the one closing report.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      close_out();
    end
  end

  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    t_regs();
    t_line();
    t_fault();
    t_vbus();
    t_detach();
    t_rx();
    t_abort();
    close_out();
  end
endmodule : test_ulev_event_phy
